// >>> rtl/arsc_pkg.sv
package arsc_pkg;
	// Clock, tracking timing and result format
	localparam int CLK_HZ = 20_000_000;
	localparam int TRACK_MIN_NS = 500;
	localparam int TRACK_MIN_CYC =
		(TRACK_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PRESCALE_DEF = 16;
	localparam int RES_W = 10;
	localparam int SIGN_POS = 9;
	// Codes and reset values
	localparam logic [9:0] FULL_SCALE = 10'h3FF;
	localparam logic [9:0] DIFF_MIN = 10'h200;
	localparam logic [9:0] DIFF_MAX = 10'h1FF;
	localparam logic [9:0] CODE_RST = 10'h000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [5:0] PAD_ZERO = 6'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	// Sleep mode encodings
	localparam logic [2:0] SLP_IDLE = 3'h0;
	localparam logic [2:0] SLP_NOISE = 3'h1;
	localparam logic [2:0] SLP_PDOWN = 3'h2;
	localparam logic [2:0] SLP_PSAVE = 3'h3;
	localparam logic [2:0] SLP_STBY = 3'h6;
	// Converter sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_TRACK = 2'b01,
		ST_CONV = 2'b10
	} arsc_state_t;
endpackage : arsc_pkg

// >>> rtl/arsc_sar.sv
`timescale 1ns/10ps
module arsc_sar
	import arsc_pkg::*;
#(
	parameter int W = RES_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic start,
	input wire logic step,
	input wire logic cmp,
	// Results
	output logic [W-1:0] trial,
	output logic [W-1:0] code,
	output logic busy,
	output logic done
);
	logic [W-1:0] bit_sel;
	logic [W-1:0] next_bit_sel;
	logic [W-1:0] next_code;
	logic next_busy;
	logic next_done;

	// Trial word under test
	assign trial = code | bit_sel;

	// One bit resolved per converter tick, MSB first
	always_comb begin
		next_code = code;
		next_bit_sel = bit_sel;
		next_busy = busy;
		next_done = 1'b0;
		if (start) begin
			next_code = '0;
			next_bit_sel = {1'b1, {(W-1){1'b0}}};
			next_busy = 1'b1;
		end else if (busy && step) begin
			if (cmp)
				next_code = code | bit_sel;
			next_bit_sel = bit_sel >> 1;
			if (bit_sel[0]) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	// Register the search state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			code <= '0;
			bit_sel <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			code <= next_code;
			bit_sel <= next_bit_sel;
			busy <= next_busy;
			done <= next_done;
		end
	end

	// Done only ever ends a running search
	done_source_a: assert property (@(posedge clk) disable iff (!resetn)
		done |-> $past(busy) && !busy)
		else $error("sar done without a running search");
endmodule : arsc_sar

// >>> rtl/arsc_top.sv
`timescale 1ns/10ps
module arsc_top
	import arsc_pkg::*;
#(
	parameter int PRESCALE = PRESCALE_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Converter control from the CPU side
	input wire logic converter_enable,
	input wire logic start_request,
	input wire logic differential_mode,
	input wire logic left_adjust_select,
	input wire logic [1:0] tracking_hold_extension,
	input wire logic irq_enable,
	input wire logic flag_clear,
	// CPU sleep handshake
	input wire logic sleep_cmd,
	input wire logic [2:0] sleep_mode,
	input wire logic other_irq,
	// Analog front end
	input wire logic comparator_in,
	input wire logic over_range_in,
	output logic sample_switch,
	output logic [9:0] dac_code,
	output logic half_rate_converter_clock,
	output logic converter_power,
	// Results and status
	output logic [7:0] result_low_byte,
	output logic [7:0] result_high_byte,
	output logic conversion_done_flag,
	output logic conversion_irq,
	output logic cpu_halted,
	output logic busy
);
	localparam int DW = $clog2(PRESCALE);
	localparam logic [DW-1:0] DIV_LAST = DW'(PRESCALE - 1);
	localparam logic [7:0] TRACK_MIN = 8'(TRACK_MIN_CYC);

	// Synchroniser stages
	logic cmp_m, cmp_s, ovr_m, ovr_s;
	// Divider
	logic [DW-1:0] div_cnt, next_div_cnt;
	logic adc_tick;
	logic next_half;
	// Sequencer
	arsc_state_t state, next_state;
	logic [7:0] track_cnt, next_track_cnt;
	logic [1:0] ext_cnt, next_ext_cnt;
	logic ovr_q, next_ovr_q;
	logic diff_q, next_diff_q;
	logic track_end;
	logic sar_start;
	logic auto_req, next_auto_req;
	// SAR engine
	logic [9:0] sar_trial, sar_code;
	logic sar_busy, sar_done;
	// Result path
	logic [9:0] word;
	logic [7:0] next_low, next_high;
	logic next_flag, next_irq;
	logic next_halted;
	logic sleep_conv_mode;
	logic [7:0] track_len;

	// Two-stage synchronisers for the analog comparator outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmp_m <= 1'b0;
			cmp_s <= 1'b0;
			ovr_m <= 1'b0;
			ovr_s <= 1'b0;
		end else begin
			cmp_m <= comparator_in;
			cmp_s <= cmp_m;
			ovr_m <= over_range_in;
			ovr_s <= ovr_m;
		end
	end

	// Converter clock enable and half-rate clock
	assign adc_tick = (div_cnt == DIV_LAST);

	always_comb begin
		next_div_cnt = adc_tick ? '0 : div_cnt + 1'b1;
		next_half = half_rate_converter_clock;
		if (!converter_enable) begin
			next_div_cnt = '0;
			next_half = 1'b0;
		end else if (adc_tick) begin
			next_half = ~half_rate_converter_clock;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt <= '0;
			half_rate_converter_clock <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			half_rate_converter_clock <= next_half;
		end
	end

	// Modes in which the halted CPU lets a conversion run
	assign sleep_conv_mode = (sleep_mode == SLP_NOISE) ||
		(sleep_mode == SLP_IDLE);

	// Tracking ends after the minimum, then on a converter tick
	always_comb begin
		track_end = 1'b0;
		if (state == ST_TRACK && track_cnt >= TRACK_MIN && adc_tick) begin
			if (diff_q)
				track_end = half_rate_converter_clock;
			else
				track_end = (ext_cnt >= tracking_hold_extension);
		end
	end

	assign sar_start = track_end;

	// Sequencer: idle, track, convert
	always_comb begin
		next_state = state;
		next_track_cnt = track_cnt;
		next_ext_cnt = ext_cnt;
		next_ovr_q = ovr_q;
		next_diff_q = diff_q;
		next_auto_req = auto_req;
		// Sleep entry in idle or noise mode requests one conversion
		if (sleep_cmd && !cpu_halted && sleep_conv_mode &&
			converter_enable && state == ST_IDLE)
			next_auto_req = 1'b1;
		case (state)
			ST_IDLE: begin
				if (converter_enable && (start_request ||
					(auto_req && cpu_halted))) begin
					next_state = ST_TRACK;
					next_track_cnt = CNT_RST;
					next_ext_cnt = 2'b00;
					next_diff_q = differential_mode;
					next_auto_req = 1'b0;
				end
			end
			ST_TRACK: begin
				if (track_cnt != 8'hFF)
					next_track_cnt = track_cnt + 8'h01;
				if (track_cnt >= TRACK_MIN && adc_tick &&
					ext_cnt != 2'b11)
					next_ext_cnt = ext_cnt + 2'b01;
				if (track_end) begin
					next_state = ST_CONV;
					next_ovr_q = ovr_s;
				end
			end
			ST_CONV: begin
				if (sar_done)
					next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (!converter_enable) begin
			next_state = ST_IDLE;
			next_auto_req = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			track_cnt <= CNT_RST;
			ext_cnt <= 2'b00;
			ovr_q <= 1'b0;
			diff_q <= 1'b0;
			auto_req <= 1'b0;
		end else begin
			state <= next_state;
			track_cnt <= next_track_cnt;
			ext_cnt <= next_ext_cnt;
			ovr_q <= next_ovr_q;
			diff_q <= next_diff_q;
			auto_req <= next_auto_req;
		end
	end

	// Successive approximation search
	arsc_sar #(
		.W(RES_W)
	) u_sar (
		.clk(clk),
		.resetn(resetn),
		.start(sar_start),
		.step(adc_tick && state == ST_CONV),
		.cmp(cmp_s),
		.trial(sar_trial),
		.code(sar_code),
		.busy(sar_busy),
		.done(sar_done)
	);

	conv_busy_a: assert property (@(posedge clk) disable iff (!resetn)
		state == ST_CONV && !sar_done |-> sar_busy)
		else $error("convert state without a running search");

	// Result coding and alignment
	always_comb begin
		if (diff_q)
			word = {~sar_code[SIGN_POS], sar_code[8:0]};
		else if (ovr_q)
			word = FULL_SCALE;
		else
			word = sar_code;
		if (left_adjust_select) begin
			next_high = word[9:2];
			next_low = {word[1:0], PAD_ZERO};
		end else begin
			next_high = {PAD_ZERO, word[9:8]};
			next_low = word[7:0];
		end
	end

	// Flag, interrupt and CPU sleep state
	always_comb begin
		next_flag = conversion_done_flag;
		if (flag_clear)
			next_flag = 1'b0;
		if (sar_done)
			next_flag = 1'b1;
		next_irq = next_flag && irq_enable;
		next_halted = cpu_halted;
		if (sleep_cmd && !cpu_halted)
			next_halted = 1'b1;
		else if (cpu_halted && (other_irq || conversion_irq))
			next_halted = 1'b0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			result_low_byte <= BYTE_RST;
			result_high_byte <= BYTE_RST;
			conversion_done_flag <= 1'b0;
			conversion_irq <= 1'b0;
			cpu_halted <= 1'b0;
		end else begin
			if (sar_done) begin
				result_low_byte <= next_low;
				result_high_byte <= next_high;
			end
			conversion_done_flag <= next_flag;
			conversion_irq <= next_irq;
			cpu_halted <= next_halted;
		end
	end

	// Analog front end drive, all registered
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample_switch <= 1'b0;
			dac_code <= CODE_RST;
			converter_power <= 1'b0;
			busy <= 1'b0;
		end else begin
			sample_switch <= (next_state == ST_TRACK);
			dac_code <= sar_trial;
			converter_power <= converter_enable;
			busy <= (next_state != ST_IDLE);
		end
	end

	// Length of the current tracking window, for checking only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			track_len <= CNT_RST;
		else if (!sample_switch)
			track_len <= CNT_RST;
		else if (track_len != 8'hFF)
			track_len <= track_len + 8'h01;
	end

	track_min_a: assert property (@(posedge clk) disable iff (!resetn)
		$fell(sample_switch) && converter_power |-> track_len >= TRACK_MIN)
		else $error("tracking shorter than the minimum");

	done_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		sar_done |=> conversion_done_flag)
		else $error("done flag missed a finished conversion");

	left_pad_a: assert property (@(posedge clk) disable iff (!resetn)
		sar_done && left_adjust_select |=> result_low_byte[5:0] == PAD_ZERO)
		else $error("left adjusted low byte not padded");

	right_pad_a: assert property (@(posedge clk) disable iff (!resetn)
		sar_done && !left_adjust_select |=>
		result_high_byte[7:2] == PAD_ZERO)
		else $error("right adjusted high byte not padded");

	saturate_a: assert property (@(posedge clk) disable iff (!resetn)
		sar_done && !diff_q && ovr_q && !left_adjust_select |=>
		{result_high_byte[1:0], result_low_byte} == FULL_SCALE)
		else $error("over range input did not saturate");

	sign_bit_a: assert property (@(posedge clk) disable iff (!resetn)
		sar_done && diff_q && left_adjust_select |=>
		result_high_byte[7] == ~$past(sar_code[SIGN_POS]))
		else $error("differential sign bit wrong");

	other_wake_a: assert property (@(posedge clk) disable iff (!resetn)
		cpu_halted && other_irq |=> !cpu_halted)
		else $error("other interrupt did not wake the CPU");

	stay_awake_a: assert property (@(posedge clk) disable iff (!resetn)
		!cpu_halted && !sleep_cmd |=> !cpu_halted)
		else $error("CPU halted without a sleep command");

	done_irq_a: assert property (@(posedge clk) disable iff (!resetn)
		sar_done && irq_enable |=> conversion_irq ##1 !cpu_halted)
		else $error("conversion end did not raise the wake request");

	power_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		converter_enable && sleep_cmd |=> converter_power)
		else $error("converter switched off on sleep entry");
endmodule : arsc_top

// >>> tb/arsc_analog_model.sv
`timescale 1ns/10ps
module arsc_analog_model (
	// Converter side
	input wire logic [9:0] dac_code,
	// Scenario control
	input wire logic [9:0] level,
	input wire logic above_ref,
	// Analog answers
	output logic comparator_in,
	output logic over_range_in
);
	// Ideal comparator, input half a step above its own code
	assign comparator_in = (level >= dac_code);
	// Reference overrun detector
	assign over_range_in = above_ref;
endmodule : arsc_analog_model

// >>> tb/adc_result_and_sleep_control_tb.sv
`timescale 1ns/10ps
module adc_result_and_sleep_control_tb import arsc_pkg::*;;
	localparam int PS = 4;
	logic clk = 1'b0;
	logic resetn, converter_enable, start_request, differential_mode;
	logic left_adjust_select, irq_enable, flag_clear, sleep_cmd, other_irq;
	logic [1:0] tracking_hold_extension;
	logic [2:0] sleep_mode;
	logic comparator_in, over_range_in, sample_switch, half_rate_clk;
	logic converter_power, conversion_done_flag, conversion_irq;
	logic cpu_halted, busy, above_ref;
	logic [9:0] dac_code, level;
	logic [7:0] result_low_byte, result_high_byte;
	int mismatches = 0;
	int checked = 0;
	int track_len;

	// Free-running clock
	always #25 clk = ~clk;

	arsc_top #(.PRESCALE(PS)) dut (.clk(clk), .resetn(resetn),
		.converter_enable(converter_enable), .start_request(start_request),
		.differential_mode(differential_mode),
		.left_adjust_select(left_adjust_select),
		.tracking_hold_extension(tracking_hold_extension),
		.irq_enable(irq_enable), .flag_clear(flag_clear),
		.sleep_cmd(sleep_cmd), .sleep_mode(sleep_mode),
		.other_irq(other_irq), .comparator_in(comparator_in),
		.over_range_in(over_range_in), .sample_switch(sample_switch),
		.dac_code(dac_code), .half_rate_converter_clock(half_rate_clk),
		.converter_power(converter_power),
		.result_low_byte(result_low_byte),
		.result_high_byte(result_high_byte),
		.conversion_done_flag(conversion_done_flag),
		.conversion_irq(conversion_irq), .cpu_halted(cpu_halted),
		.busy(busy));

	arsc_analog_model model (.dac_code(dac_code), .level(level),
		.above_ref(above_ref), .comparator_in(comparator_in),
		.over_range_in(over_range_in));

	// Verdict and end of run
	task automatic conclude;
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	// Value comparison
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait on done flag (0) or halt status (1)
	task automatic wait_on(input int sel, input logic val);
		int n;
		logic s;
		n = 0;
		s = ~val;
		while (s !== val) begin
			@(negedge clk);
			s = (sel == 0) ? conversion_done_flag : cpu_halted;
			if (sel == 0 && sample_switch === 1'b1) begin
				track_len++;
			end
			n++;
			if (n > 3000) begin
				mismatches++;
				conclude();
			end
		end
	endtask : wait_on

	// One-cycle pulse: start, clear, sleep or other interrupt
	task automatic pulse(input int sel);
		@(posedge clk);
		case (sel)
			0: start_request <= 1'b1;
			1: flag_clear <= 1'b1;
			2: sleep_cmd <= 1'b1;
			default: other_irq <= 1'b1;
		endcase
		@(posedge clk);
		start_request <= 1'b0;
		flag_clear <= 1'b0;
		sleep_cmd <= 1'b0;
		other_irq <= 1'b0;
	endtask : pulse

	// Set up the source and coding, used by every conversion
	task automatic setup(input logic diff, input logic left,
		input logic [1:0] ext, input logic [9:0] lvl, input logic over);
		@(posedge clk);
		differential_mode <= diff;
		left_adjust_select <= left;
		tracking_hold_extension <= ext;
		level <= lvl;
		above_ref <= over;
		track_len = 0;
	endtask : setup

	// Converts once, checks bytes at the flag edge, then clears
	task automatic convert(input logic diff, input logic left,
		input logic [1:0] ext, input logic [9:0] lvl, input logic over,
		input logic [15:0] exp);
		setup(diff, left, ext, lvl, over);
		pulse(0);
		wait_on(0, 1'b1);
		chk({result_high_byte, result_low_byte}, exp);
		chk({6'h00, dac_code}, {6'h00, lvl});
		chk({15'h0000, conversion_irq}, {15'h0000, irq_enable});
		pulse(1);
		@(negedge clk);
		chk({15'h0, conversion_done_flag}, 16'h0);
	endtask : convert

	// Single-ended codes, both alignments and the end points
	task automatic t_single;
		convert(1'b0, 1'b0, 2'h0, 10'h2A5, 1'b0, 16'h02A5);
		convert(1'b0, 1'b1, 2'h0, 10'h2A5, 1'b0, 16'hA940);
		convert(1'b0, 1'b0, 2'h0, 10'h000, 1'b0, 16'h0000);
		convert(1'b0, 1'b1, 2'h0, 10'h3FF, 1'b0, 16'hFFC0);
	endtask : t_single

	// Differential two's complement codes and sign bit
	task automatic t_diff;
		logic h;
		convert(1'b1, 1'b1, 2'h0, 10'h070, 1'b0, 16'h9C00);
		convert(1'b1, 1'b0, 2'h0, 10'h070, 1'b0, 16'h0270);
		convert(1'b1, 1'b0, 2'h0, 10'h3FF, 1'b0, 16'h01FF);
		convert(1'b1, 1'b0, 2'h0, 10'h000, 1'b0, 16'h0200);
		chk({15'h0, track_len >= TRACK_MIN_CYC}, 16'h1);
		// Half-rate clock flips once per converter tick
		h = half_rate_clk;
		repeat (PS) @(negedge clk);
		chk({15'h0000, half_rate_clk}, {15'h0000, ~h});
	endtask : t_diff

	// Input above reference saturates, never wraps
	task automatic t_over;
		@(posedge clk);
		irq_enable <= 1'b0;
		convert(1'b0, 1'b0, 2'h0, 10'h155, 1'b1, 16'h03FF);
		convert(1'b0, 1'b1, 2'h0, 10'h001, 1'b1, 16'hFFC0);
		@(posedge clk);
		irq_enable <= 1'b1;
	endtask : t_over

	// Minimum tracking and its extension in converter ticks
	task automatic t_tracking;
		convert(1'b0, 1'b0, 2'h0, 10'h011, 1'b0, 16'h0011);
		chk({15'h0, track_len >= TRACK_MIN_CYC}, 16'h1);
		convert(1'b0, 1'b0, 2'h3, 10'h011, 1'b0, 16'h0011);
		chk({15'h0, track_len >= TRACK_MIN_CYC + 2 * PS}, 16'h1);
	endtask : t_tracking

	// Idle or noise-reduction sleep: conversion wakes the CPU
	task automatic t_noise_sleep(input logic [2:0] mode);
		setup(1'b0, 1'b0, 2'h0, 10'h123, 1'b0);
		sleep_mode <= mode;
		pulse(2);
		wait_on(1, 1'b1);
		wait_on(1, 1'b0);
		chk({14'h0, conversion_done_flag, conversion_irq}, 16'h3);
		chk({result_high_byte, result_low_byte}, 16'h0123);
		repeat (20) @(negedge clk);
		chk({15'h0, cpu_halted}, 16'h0);
		pulse(1);
	endtask : t_noise_sleep

	// Another interrupt wakes first, request still raised later
	task automatic t_other_wake;
		setup(1'b0, 1'b0, 2'h0, 10'h0F0, 1'b0);
		pulse(2);
		wait_on(1, 1'b1);
		pulse(3);
		wait_on(1, 1'b0);
		chk({15'h0, conversion_done_flag}, 16'h0);
		wait_on(0, 1'b1);
		@(negedge clk);
		chk({14'h0, conversion_irq, cpu_halted}, 16'h2);
		pulse(1);
	endtask : t_other_wake

	// Deeper sleep modes leave the converter powered and idle
	task automatic t_deep_sleep;
		logic [2:0] modes [3];
		modes = '{SLP_PDOWN, SLP_PSAVE, SLP_STBY};
		foreach (modes[i]) begin
			@(posedge clk);
			sleep_mode <= modes[i];
			pulse(2);
			wait_on(1, 1'b1);
			repeat (5) @(negedge clk);
			chk({14'h0, converter_power, busy}, 16'h2);
			pulse(3);
			wait_on(1, 1'b0);
		end
		// Only the enable bit removes converter power
		@(posedge clk);
		converter_enable <= 1'b0;
		repeat (2) @(negedge clk);
		chk({14'h0, converter_power, half_rate_clk}, 16'h0);
		@(posedge clk);
		converter_enable <= 1'b1;
	endtask : t_deep_sleep

	// Main sequence
	initial begin
		resetn <= 1'b0;
		converter_enable <= 1'b0;
		start_request <= 1'b0;
		differential_mode <= 1'b0;
		left_adjust_select <= 1'b0;
		tracking_hold_extension <= 2'h0;
		irq_enable <= 1'b1;
		flag_clear <= 1'b0;
		sleep_cmd <= 1'b0;
		sleep_mode <= SLP_IDLE;
		other_irq <= 1'b0;
		level <= 10'h000;
		above_ref <= 1'b0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		converter_enable <= 1'b1;
		repeat (4) @(posedge clk);
		t_single();
		t_diff();
		t_over();
		t_tracking();
		t_noise_sleep(SLP_NOISE);
		t_noise_sleep(SLP_IDLE);
		t_other_wake();
		t_deep_sleep();
		conclude();
	end
endmodule : adc_result_and_sleep_control_tb
